// >>> design/ncpi_pkg.sv
// Purpose: shared constants and types for the numeric coprocessor interface
// Assumes: cpu double-rate clock of 250 MHz (4 ns period)
// Notes: port addresses, setup bit position and all timing counts live here

package ncpi_pkg;

  // ---------------------------------------------------------------
  // i/o port addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] COPRO_BUSY_CLEAR_ADDR = 8'hF0;    // copro_busy_clear, write only
  localparam logic [7:0] COPRO_RESET_TRIGGER_ADDR = 8'hF1; // copro_reset_trigger, write only

  // ---------------------------------------------------------------
  // misc_setup_reg field
  // ---------------------------------------------------------------
  localparam int MISC_COPRO_RESET_DISABLE_BIT = 6; // 1 blocks port-triggered copro reset

  // ---------------------------------------------------------------
  // timing, in cpu double-rate clock cycles
  // ---------------------------------------------------------------
  localparam logic [7:0] COPRO_RESET_CYCLES = 8'h50;    // 80 cycles of copro reset
  localparam logic [7:0] READY_DELAY_CYCLES = 8'h32;    // 50 cycles to ready pulse
  localparam logic [7:0] SYS_RESET_HOLD_CYCLES = 8'h10; // cpu reset hold after release
  localparam logic [7:0] BUSY_TRAIL_CYCLES = 8'h08;     // busy held past cpu reset fall

  // refresh periods in their own unit, and derived counts
  localparam int CLOCK_PERIOD_PS = 4000;           // 250 MHz
  localparam int REFRESH_FAST_PS = 15625000;       // 15.625 us
  localparam int REFRESH_SLOW_PS = 125000000;      // 125 us
  localparam int REFRESH_FAST_CYCLES = REFRESH_FAST_PS / CLOCK_PERIOD_PS;
  localparam int REFRESH_SLOW_CYCLES = REFRESH_SLOW_PS / CLOCK_PERIOD_PS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // coprocessor status pins, active-high inside the block
  typedef struct packed {
    logic error;       // copro_error_in active
    logic busy;        // copro_busy_in active
    logic operand_req; // copro_operand_req_in
  } ncpi_copro_pins_type;

  // reset sequencer states
  typedef enum logic [2:0] {
    SEQ_SYS_HOLD,   // system reset: cpu and copro held in reset
    SEQ_SYS_TRAIL,  // cpu reset released, self-test busy still held
    SEQ_IDLE,       // normal running
    SEQ_CO_RESET,   // port-triggered copro reset active
    SEQ_CO_WAIT     // counting down to the ready pulse
  } ncpi_seq_type;

endpackage : ncpi_pkg

// >>> design/ncpi_refresh_tick.sv
// Purpose: one-cycle tick once every refresh period
// Assumes: counts are at least 2 and fit in the counter width
// Notes: select may change at any time; counter restarts on overflow

`timescale 1ns/1ps

module ncpi_refresh_tick #(
  parameter int FAST_CYCLES = ncpi_pkg::REFRESH_FAST_CYCLES,
  parameter int SLOW_CYCLES = ncpi_pkg::REFRESH_SLOW_CYCLES,
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow_sel,
  output logic tick
);

  // ---------------------------------------------------------------
  // period counter
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] count;      // cycles in current period
  logic [WIDTH-1:0] next_count; // next count
  logic next_tick;              // next tick
  logic [WIDTH-1:0] last;       // final count of the period

  // wrap point and counting
  always_comb begin
    last = slow_sel ? WIDTH'(SLOW_CYCLES - 1) : WIDTH'(FAST_CYCLES - 1);
    next_tick = 1'b0;
    next_count = count + WIDTH'(1);
    if (count >= last) begin // period over
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule : ncpi_refresh_tick

// >>> design/ncpi_copro_if.sv
// Purpose: glue between host cpu and numeric coprocessor (busy, error, reset)
// Assumes: io strobe and address come from cpu bus logic on CLOCK
// Notes: coprocessor pins are asynchronous and pass two flip-flops
//
// Behaviour
// - port F1 write: copro reset for 80 cycles
// - ready pulse 50 cycles after F1 copro reset falls
// - setup bit 6 set blocks F1 reset
// - active copro error raises irq 13
// - error latches busy; F0, F1, reset clear
// - copro busy always passed to cpu busy
// - system reset also drives cpu busy
// - busy pulsed every refresh period
// - error fall captures busy, ored into request
// - F0 write clears captured busy term
// - copro reset asserted during system reset
// - busy spans cpu reset fall by eight cycles

`timescale 1ns/1ps

module ncpi_copro_if #(
  parameter int REFRESH_SLOW_COUNT = ncpi_pkg::REFRESH_SLOW_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic IO_WRITE,
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] MISC_SETUP_REG,
  input wire logic REFRESH_SLOW,
  input wire logic COPRO_ERROR_IN_N,
  input wire logic COPRO_BUSY_IN_N,
  input wire logic COPRO_OPERAND_REQ_IN,
  output logic CPU_BUSY_OUT_N,
  output logic CPU_OPERAND_REQ_OUT,
  output logic COPRO_RESET_OUT,
  output logic CPU_RESET_OUT,
  output logic READY_OUT_N,
  output logic IRQ13_OUT
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // io write to a given port; reads never match
  function automatic logic port_write(input logic wr, input logic [7:0] addr,
                                      input logic [7:0] port);
    port_write = wr && (addr == port);
  endfunction : port_write

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  ncpi_pkg::ncpi_copro_pins_type pins_raw;   // pins as active-high
  ncpi_pkg::ncpi_copro_pins_type pins_meta;  // first stage, read by second only
  ncpi_pkg::ncpi_copro_pins_type pins_sync;  // second stage
  logic error_prev;                          // error one cycle back, edge detect
  logic next_error_prev;                     // next error_prev

  // invert the active-low pins
  always_comb begin
    pins_raw.error = ~COPRO_ERROR_IN_N;
    pins_raw.busy = ~COPRO_BUSY_IN_N;
    pins_raw.operand_req = COPRO_OPERAND_REQ_IN;
    next_error_prev = pins_sync.error;
  end

  // two-stage synchroniser plus edge history
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pins_meta <= '0;
      pins_sync <= '0;
      error_prev <= 1'b0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
      error_prev <= next_error_prev;
    end
  end

  // ---------------------------------------------------------------
  // port decode
  // ---------------------------------------------------------------
  logic wr_busy_clear;    // write to F0, data ignored
  logic wr_reset_trigger; // write to F1, data ignored
  logic reset_disabled;   // setup bit blocks port reset

  always_comb begin
    wr_busy_clear = port_write(IO_WRITE, IO_ADDR, ncpi_pkg::COPRO_BUSY_CLEAR_ADDR);
    wr_reset_trigger = port_write(IO_WRITE, IO_ADDR,
                                  ncpi_pkg::COPRO_RESET_TRIGGER_ADDR);
    reset_disabled = MISC_SETUP_REG[ncpi_pkg::MISC_COPRO_RESET_DISABLE_BIT];
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  ncpi_pkg::ncpi_seq_type state;      // current state
  ncpi_pkg::ncpi_seq_type next_state; // next state
  logic [7:0] count;                  // cycles within state
  logic [7:0] next_count;             // next count
  logic next_copro_reset;             // next COPRO_RESET_OUT
  logic next_cpu_reset;               // next CPU_RESET_OUT
  logic next_ready_n;                 // next READY_OUT_N
  logic sys_busy;                     // reset-time busy source

  // state transitions and counting
  always_comb begin
    next_state = state;
    next_count = count + 8'h01;
    next_ready_n = 1'b1;
    case (state)
      ncpi_pkg::SEQ_SYS_HOLD: begin // hold cpu and copro after release
        if (count == ncpi_pkg::SYS_RESET_HOLD_CYCLES - 8'h01) begin
          next_state = ncpi_pkg::SEQ_SYS_TRAIL;
          next_count = 8'h00;
        end
      end
      ncpi_pkg::SEQ_SYS_TRAIL: begin // busy outlasts cpu reset fall
        if (count == ncpi_pkg::BUSY_TRAIL_CYCLES - 8'h01) begin
          next_state = ncpi_pkg::SEQ_IDLE;
          next_count = 8'h00;
        end
      end
      ncpi_pkg::SEQ_IDLE: begin // wait for a port reset
        next_count = 8'h00;
        if (wr_reset_trigger && !reset_disabled) begin
          next_state = ncpi_pkg::SEQ_CO_RESET;
        end
      end
      ncpi_pkg::SEQ_CO_RESET: begin // further F1 writes ignored here
        if (count == ncpi_pkg::COPRO_RESET_CYCLES - 8'h01) begin
          next_state = ncpi_pkg::SEQ_CO_WAIT;
          next_count = 8'h00;
        end
      end
      ncpi_pkg::SEQ_CO_WAIT: begin // count to the ready pulse
        if (count == ncpi_pkg::READY_DELAY_CYCLES - 8'h01) begin
          next_state = ncpi_pkg::SEQ_IDLE;
          next_count = 8'h00;
          next_ready_n = 1'b0;
        end
      end
      default: begin // unused codes recover to idle
        next_state = ncpi_pkg::SEQ_IDLE;
        next_count = 8'h00;
      end
    endcase
    // outputs follow the state they belong to
    next_copro_reset = (next_state == ncpi_pkg::SEQ_SYS_HOLD) ||
                       (next_state == ncpi_pkg::SEQ_CO_RESET);
    next_cpu_reset = (next_state == ncpi_pkg::SEQ_SYS_HOLD);
    sys_busy = (next_state == ncpi_pkg::SEQ_SYS_HOLD) ||
               (next_state == ncpi_pkg::SEQ_SYS_TRAIL);
  end

  // sequencer registers; reset parks in system hold
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ncpi_pkg::SEQ_SYS_HOLD;
      count <= 8'h00;
      COPRO_RESET_OUT <= 1'b1;
      CPU_RESET_OUT <= 1'b1;
      READY_OUT_N <= 1'b1;
    end else begin
      state <= next_state;
      count <= next_count;
      COPRO_RESET_OUT <= next_copro_reset;
      CPU_RESET_OUT <= next_cpu_reset;
      READY_OUT_N <= next_ready_n;
    end
  end

  // ---------------------------------------------------------------
  // refresh-period busy tick
  // ---------------------------------------------------------------
  logic refresh_tick; // one cycle each refresh period

  ncpi_refresh_tick #(
    .FAST_CYCLES(ncpi_pkg::REFRESH_FAST_CYCLES),
    .SLOW_CYCLES(REFRESH_SLOW_COUNT),
    .WIDTH(16)
  ) u_refresh_tick (
    .clk(CLOCK),
    .rst_n(RST_N),
    .slow_sel(REFRESH_SLOW),
    .tick(refresh_tick)
  );

  // ---------------------------------------------------------------
  // error latch, captured busy and cpu-side outputs
  // ---------------------------------------------------------------
  logic err_latch;          // latched error busy
  logic next_err_latch;     // next err_latch
  logic cap_busy;           // busy captured at error onset
  logic next_cap_busy;      // next cap_busy
  logic next_busy_n;        // next CPU_BUSY_OUT_N
  logic next_operand_req;   // next CPU_OPERAND_REQ_OUT
  logic next_irq;           // next IRQ13_OUT
  logic error_fall;         // error pin just went active

  // latch updates: a set in the clearing cycle wins
  always_comb begin
    error_fall = pins_sync.error && !error_prev;
    next_err_latch = err_latch;
    if (wr_busy_clear || wr_reset_trigger || COPRO_RESET_OUT) begin
      next_err_latch = 1'b0;
    end
    if (pins_sync.error) begin
      next_err_latch = 1'b1;
    end
    next_cap_busy = cap_busy;
    if (wr_busy_clear) begin
      next_cap_busy = 1'b0;
    end
    if (error_fall) begin
      next_cap_busy = pins_sync.busy;
    end
    // busy sources combined, active low at the pin
    next_busy_n = ~(pins_sync.busy | next_err_latch | sys_busy |
                    refresh_tick);
    next_operand_req = pins_sync.operand_req | next_cap_busy;
    next_irq = pins_sync.error;
  end

  // latch and output registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      err_latch <= 1'b0;
      cap_busy <= 1'b0;
      CPU_BUSY_OUT_N <= 1'b0;
      CPU_OPERAND_REQ_OUT <= 1'b0;
      IRQ13_OUT <= 1'b0;
    end else begin
      err_latch <= next_err_latch;
      cap_busy <= next_cap_busy;
      CPU_BUSY_OUT_N <= next_busy_n;
      CPU_OPERAND_REQ_OUT <= next_operand_req;
      IRQ13_OUT <= next_irq;
    end
  end

endmodule : ncpi_copro_if

// >>> tb/ncpi_copro_if_sva.sv
// Purpose: port-level checks for the coprocessor glue
// Assumes: single CLOCK domain, RST_N async active low
// Notes: bound onto ncpi_copro_if below
`timescale 1ns/1ps
module ncpi_copro_if_sva #(
  parameter int REFRESH_SLOW_COUNT = 40
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic IO_WRITE,
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] MISC_SETUP_REG,
  input wire logic REFRESH_SLOW,
  input wire logic COPRO_ERROR_IN_N,
  input wire logic COPRO_BUSY_IN_N,
  input wire logic COPRO_OPERAND_REQ_IN,
  input wire logic CPU_BUSY_OUT_N,
  input wire logic CPU_OPERAND_REQ_OUT,
  input wire logic COPRO_RESET_OUT,
  input wire logic CPU_RESET_OUT,
  input wire logic READY_OUT_N,
  input wire logic IRQ13_OUT
);
  // ------------------------------------------------
  // helper: length of the current copro reset
  // ------------------------------------------------
  logic [7:0] run; // cycles copro reset seen high
  logic [7:0] next_run;
  always_comb begin
    next_run = COPRO_RESET_OUT ? run + 8'h01 : 8'h00;
  end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      run <= 8'h00;
    end else begin
      run <= next_run;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  property p_len; $fell(COPRO_RESET_OUT) && !$past(CPU_RESET_OUT) |-> run == 8'h50; endproperty
  a_len: assert property (p_len) else $error("copro reset width");
  property p_rdy; $fell(COPRO_RESET_OUT) && !$past(CPU_RESET_OUT)
    |-> ##50 !READY_OUT_N ##1 READY_OUT_N; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_dis; IO_WRITE && IO_ADDR == 8'hF1 && MISC_SETUP_REG[6] && !COPRO_RESET_OUT
    |=> !COPRO_RESET_OUT [*2]; endproperty
  a_dis: assert property (p_dis) else $error("disabled reset ran");
  property p_irq; $stable(COPRO_ERROR_IN_N) [*4] |-> IRQ13_OUT == !COPRO_ERROR_IN_N; endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_lat; IRQ13_OUT |-> !CPU_BUSY_OUT_N; endproperty
  a_lat: assert property (p_lat) else $error("error not busy");
  // a copro reset that ended in the cycle before also cleared the latch
  property p_hold; $fell(IRQ13_OUT) && !IO_WRITE && !$past(IO_WRITE) && !COPRO_RESET_OUT
    && !$past(COPRO_RESET_OUT) |-> !CPU_BUSY_OUT_N; endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_pass; !COPRO_BUSY_IN_N [*4] |-> !CPU_BUSY_OUT_N; endproperty
  a_pass: assert property (p_pass) else $error("busy not passed");
  property p_sys; $rose(RST_N) |-> COPRO_RESET_OUT && CPU_RESET_OUT && !CPU_BUSY_OUT_N;
  endproperty
  a_sys: assert property (p_sys) else $error("system reset outputs");
  property p_trail; $fell(CPU_RESET_OUT) |-> !$past(CPU_BUSY_OUT_N, 8) ##0 !CPU_BUSY_OUT_N [*8];
  endproperty
  a_trail: assert property (p_trail) else $error("self-test busy span");
  property p_req; COPRO_OPERAND_REQ_IN [*4] |-> CPU_OPERAND_REQ_OUT; endproperty
  a_req: assert property (p_req) else $error("operand request");
  property p_clr; (!COPRO_OPERAND_REQ_IN && COPRO_ERROR_IN_N) [*4] ##0 (IO_WRITE && IO_ADDR == 8'hF0)
    |=> ##1 !CPU_OPERAND_REQ_OUT; endproperty
  a_clr: assert property (p_clr) else $error("captured busy kept");
endmodule : ncpi_copro_if_sva

bind ncpi_copro_if ncpi_copro_if_sva #(.REFRESH_SLOW_COUNT(REFRESH_SLOW_COUNT)) i_sva (
  .CLOCK(CLOCK), .RST_N(RST_N), .IO_WRITE(IO_WRITE), .IO_ADDR(IO_ADDR),
  .MISC_SETUP_REG(MISC_SETUP_REG), .REFRESH_SLOW(REFRESH_SLOW),
  .COPRO_ERROR_IN_N(COPRO_ERROR_IN_N), .COPRO_BUSY_IN_N(COPRO_BUSY_IN_N),
  .COPRO_OPERAND_REQ_IN(COPRO_OPERAND_REQ_IN), .CPU_BUSY_OUT_N(CPU_BUSY_OUT_N),
  .CPU_OPERAND_REQ_OUT(CPU_OPERAND_REQ_OUT), .COPRO_RESET_OUT(COPRO_RESET_OUT),
  .CPU_RESET_OUT(CPU_RESET_OUT), .READY_OUT_N(READY_OUT_N), .IRQ13_OUT(IRQ13_OUT));

// >>> tb/ncpi_copro_model.sv
// Purpose: behavioural coprocessor status pins
// Assumes: bench commands are active high
// Notes: pins change only after a falling edge
`timescale 1ns/1ps
module ncpi_copro_model (
  input wire logic clk,
  input wire ncpi_pkg::ncpi_copro_pins_type cmd,
  output logic error_n,
  output logic busy_n,
  output logic operand_req
);
  ncpi_pkg::ncpi_copro_pins_type pins = '0; // pin state, idle inactive
  // follow bench commands, off the sampling edge
  always @(negedge clk) begin
    pins <= cmd;
  end
  assign error_n = ~pins.error; // active low pin
  assign busy_n = ~pins.busy; // active low pin
  assign operand_req = pins.operand_req;
endmodule : ncpi_copro_model

// >>> tb/ncpi_copro_if_test.sv
// Purpose: self-checking bench for the coprocessor glue
// Assumes: slow refresh count shortened to 40 cycles
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module ncpi_copro_if_test;
  logic clk, rst_n, io_write, refresh_slow, err_n, busy_n, opreq;
  logic cpu_busy_n, cpu_opreq, co_rst, cpu_rst, ready_n, irq;
  logic [7:0] io_addr, misc;
  ncpi_pkg::ncpi_copro_pins_type cmd; // coprocessor commands
  int err_total, cmp_count, n;
  ncpi_copro_if #(.REFRESH_SLOW_COUNT(40)) i_dut (.CLOCK(clk), .RST_N(rst_n),
    .IO_WRITE(io_write), .IO_ADDR(io_addr), .MISC_SETUP_REG(misc), .REFRESH_SLOW(refresh_slow),
    .COPRO_ERROR_IN_N(err_n), .COPRO_BUSY_IN_N(busy_n), .COPRO_OPERAND_REQ_IN(opreq),
    .CPU_BUSY_OUT_N(cpu_busy_n), .CPU_OPERAND_REQ_OUT(cpu_opreq), .COPRO_RESET_OUT(co_rst),
    .CPU_RESET_OUT(cpu_rst), .READY_OUT_N(ready_n), .IRQ13_OUT(irq));
  ncpi_copro_model i_copro (.clk(clk), .cmd(cmd), .error_n(err_n), .busy_n(busy_n),
    .operand_req(opreq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask : step
  // one io write, held across one rising edge
  task automatic io_wr(input logic [7:0] a);
    io_write = 1'b1;
    io_addr = a;
    step(1);
    io_write = 1'b0;
  endtask : io_wr
  // two samples, so a one-cycle refresh pulse is not taken for busy
  task automatic chk_busy(input logic exp);
    logic s;
    s = cpu_busy_n;
    step(1);
    check(8'(s | cpu_busy_n), 8'(exp));
  endtask : chk_busy
  // bounded wait for a level, returns cycles spent
  task automatic wait_lvl(ref logic sig, input logic lvl, output int c);
    c = 0;
    while (sig !== lvl && c < 300) begin
      step(1);
      c++;
    end
    if (c == 300) begin
      err_total++;
      final_report();
    end
  endtask : wait_lvl
  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    {rst_n, io_write, refresh_slow, io_addr, misc, cmd, err_total, cmp_count} = '0;
    step(2);
    check(8'(co_rst), 8'h01);
    check(8'(cpu_busy_n), 8'h00);
    step(2);
    rst_n = 1'b1;
    wait_lvl(cpu_rst, 1'b0, n);
    wait_lvl(cpu_busy_n, 1'b1, n);
    check(8'(n), 8'h08);
    misc = 8'h40;
    io_wr(8'hF1);
    step(3);
    check(8'(co_rst), 8'h00);
    misc = 8'h00;
    io_wr(8'hF2);
    step(3);
    check(8'(co_rst), 8'h00);
    io_wr(8'hF1);
    wait_lvl(co_rst, 1'b1, n);
    wait_lvl(co_rst, 1'b0, n);
    check(8'(n), 8'h50);
    wait_lvl(ready_n, 1'b0, n);
    check(8'(n), 8'h32);
    step(1);
    check(8'(ready_n), 8'h01);
    cmd.busy = 1'b1;
    step(5);
    chk_busy(1'b0);
    cmd.error = 1'b1;
    step(5);
    check(8'(irq), 8'h01);
    cmd = '0;
    step(5);
    check(8'(irq), 8'h00);
    chk_busy(1'b0);
    check(8'(cpu_opreq), 8'h01);
    io_wr(8'hF0);
    step(3);
    chk_busy(1'b1);
    check(8'(cpu_opreq), 8'h00);
    cmd.operand_req = 1'b1;
    step(5);
    check(8'(cpu_opreq), 8'h01);
    cmd = '0;
    misc = 8'h40;
    cmd.error = 1'b1;
    step(5);
    cmd = '0;
    step(5);
    io_wr(8'hF2);
    step(3);
    chk_busy(1'b0);
    io_wr(8'hF1);
    step(3);
    chk_busy(1'b1);
    refresh_slow = 1'b1;
    n = 0;
    repeat (400) begin
      step(1);
      if (cpu_busy_n === 1'b0) n++;
    end
    check(8'(n >= 9 && n <= 11), 8'h01);
    // fast period: exactly one busy pulse in a window a bit over one period
    refresh_slow = 1'b0;
    n = 0;
    repeat (4000) begin
      step(1);
      if (cpu_busy_n === 1'b0) n++;
    end
    check(8'(n), 8'h01);
    rst_n = 1'b0;
    step(1);
    check(8'(co_rst), 8'h01);
    rst_n = 1'b1;
    step(30);
    final_report();
  end
endmodule : ncpi_copro_if_test
